//--- lsf_cfg.svh
// Constants for the LED string fault supervisor.
// Assumes a 10 MHz core clock; comparator inputs arrive already digitised.
`ifndef LSF_CFG_SVH
`define LSF_CFG_SVH

`define LSF_CLK_HZ        10_000_000
`define LSF_DET_TIME_NS   2000
`define LSF_RST_TIME_US   16000
// Least times round up to whole cycles
`define LSF_DET_CYCLES    ((`LSF_DET_TIME_NS * (`LSF_CLK_HZ / 1_000_000) + 999) / 1000)
`define LSF_RST_CYCLES    (`LSF_RST_TIME_US * (`LSF_CLK_HZ / 1_000_000))
`define LSF_CLEAN_PULSES  2

`endif

//--- lsf_chan.sv
// One string's partial-short detect, retry and recovery tracker.
// Assumes dim_rise is a one-cycle pulse on each dimming rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_cfg.svh"
module lsf_chan
  import lsf_pkg::*;
#(
  parameter int DET_CYCLES = `LSF_DET_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Qualifiers
  input  wire logic dim_high,
  input  wire logic dim_rise,
  input  wire logic candidate,
  // Results
  output logic      string_off,
  output logic      flag_req
);
  localparam int CW = $clog2(DET_CYCLES + 1);

  lsf_ch_state_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;

  if (DET_CYCLES < 1) begin : g_bad_det
    $error("DET_CYCLES must be at least one");
  end

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      LSF_ST_OK: begin
        cnt_nxt = '0;
        if (dim_high && candidate) begin
          st_nxt  = LSF_ST_TIMING;
          cnt_nxt = CW'(1);
        end
      end
      LSF_ST_TIMING: begin
        if (!dim_high || !candidate) begin
          st_nxt = LSF_ST_OK;
        end else if (cnt_r >= CW'(DET_CYCLES)) begin
          st_nxt = LSF_ST_OFF;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      LSF_ST_OFF: begin
        // Retry: string on again, re-judged for the full detect time
        if (dim_rise) begin
          st_nxt  = LSF_ST_CLEAN;
          cnt_nxt = CW'(1);
        end
      end
      LSF_ST_CLEAN: begin
        if (dim_high && candidate) begin
          if (cnt_r >= CW'(DET_CYCLES)) begin
            st_nxt = LSF_ST_OFF;
          end else begin
            cnt_nxt = cnt_r + CW'(1);
          end
        end else if (dim_rise) begin
          st_nxt = LSF_ST_OK;
        end else begin
          cnt_nxt = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r  <= LSF_ST_OK;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Flag held through the first clean pulse
  assign string_off = (st_r == LSF_ST_OFF);
  assign flag_req   = (st_r == LSF_ST_OFF) || (st_r == LSF_ST_CLEAN);
endmodule
`default_nettype wire

//--- lsf_peer.sv
// Far side of the fault wire: a controller that may pull it low.
// Assumes an external pull-up; whichever party pulls low wins.
`timescale 1ns/1ps
`default_nettype none
module lsf_peer (
  // Device side
  input  wire logic dev_oe,
  // Controller side
  input  wire logic pull_low,
  output logic      line
);
  // Open drain: released means high, never a stale value
  assign line = ~(dev_oe | pull_low);
endmodule
`default_nettype wire

//--- lsf_pkg.sv
// Types for the LED string fault supervisor.
// Assumes nothing beyond the constants header.
package lsf_pkg;
  typedef enum logic [1:0] {
    LSF_ST_OK,
    LSF_ST_TIMING,
    LSF_ST_OFF,
    LSF_ST_CLEAN
  } lsf_ch_state_t;
endpackage

//--- lsf_top.sv
// Fault supervisor for a multi-string LED driver: shared fault line and
// per-string partial-short handling. Comparator results are synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_cfg.svh"
module lsf_top
  import lsf_pkg::*;
#(
  parameter int N_STR      = 6,
  parameter int DET_CYCLES = `LSF_DET_CYCLES,
  parameter int RST_CYCLES = `LSF_RST_CYCLES
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Mode: 1 = shutdown-all, 0 = isolate-string
  input  wire logic             mode_all_out,
  // Enable / dimming input
  input  wire logic             dim_in,
  // Per-string comparator results
  input  wire logic [N_STR-1:0] above_partial_short_threshold,
  input  wire logic [N_STR-1:0] in_regulation,
  input  wire logic [N_STR-1:0] below_low_level,
  input  wire logic [N_STR-1:0] string_used,
  // Other latching fault sources
  input  wire logic             latch_fault_evt,
  // Open-drain fault line
  input  wire logic             fault_line_in,
  output logic                  fault_line_out,
  output logic                  fault_line_oe,
  // Power stage controls
  output logic                  boost_en,
  output logic                  disconnect_on,
  output logic [N_STR-1:0]      sink_en
);
  localparam int RW = $clog2(RST_CYCLES + 1);

  if (N_STR < 2) begin : g_bad_nstr
    $error("N_STR must be at least two");
  end
  if (RST_CYCLES < 1) begin : g_bad_rst
    $error("RST_CYCLES must be at least one");
  end

  logic             dim_r, dim_nxt;
  logic [RW-1:0]    low_cnt_r, low_cnt_nxt;
  logic             latch_r, latch_nxt;
  logic             ext_hold_r, ext_hold_nxt;
  logic             oe_r, oe_nxt;
  logic             boost_r, boost_nxt;
  logic [N_STR-1:0] sink_r, sink_nxt;
  logic [N_STR-1:0] cand, str_off, str_flag;
  logic             dim_rise, ext_low;

  assign dim_rise = dim_in && !dim_r;
  // External pull is a low we are not causing ourselves
  assign ext_low  = mode_all_out && !fault_line_in && !oe_r;

  genvar g;
  generate
    for (g = 0; g < N_STR; g++) begin : g_str
      logic other_reg;
      logic other_low;
      always_comb begin
        other_reg = 1'b0;
        other_low = 1'b0;
        for (int k = 0; k < N_STR; k++) begin
          if (k != g) begin
            other_reg = other_reg | (string_used[k] & in_regulation[k]);
            other_low = other_low | (string_used[k] & below_low_level[k]);
          end
        end
      end
      assign cand[g] = string_used[g] && above_partial_short_threshold[g]
                       && other_reg && other_low;
      lsf_chan #(
        .DET_CYCLES(DET_CYCLES)
      ) u_chan (
        .clk       (clk),
        .resetn    (resetn),
        .dim_high  (dim_in),
        .dim_rise  (dim_rise),
        .candidate (cand[g]),
        .string_off(str_off[g]),
        .flag_req  (str_flag[g])
      );
    end
  endgenerate

  always_comb begin
    dim_nxt     = dim_in;
    low_cnt_nxt = low_cnt_r;
    latch_nxt   = latch_r;
    if (dim_in) begin
      low_cnt_nxt = '0;
    end else if (low_cnt_r < RW'(RST_CYCLES)) begin
      low_cnt_nxt = low_cnt_r + RW'(1);
    end
    // Shutdown-all: partial short latches everything off; set beats clear.
    // Gated by dim_r so a string still off through the long low cannot re-latch
    if (latch_fault_evt || (mode_all_out && dim_r && |str_off)) begin
      latch_nxt = 1'b1;
    end else if (low_cnt_r >= RW'(RST_CYCLES)) begin
      latch_nxt = 1'b0;
    end
    // Held until line released and nothing internal pending
    ext_hold_nxt = ext_low || (ext_hold_r && (latch_nxt || |str_flag));
    if (!mode_all_out) begin
      ext_hold_nxt = 1'b0;
    end
    // Fault line follows only our own faults, never its own level
    oe_nxt    = latch_nxt || |str_flag;
    boost_nxt = !latch_nxt && !ext_hold_nxt;
    for (int i = 0; i < N_STR; i++) begin
      // Isolate mode disables only the offending string
      sink_nxt[i] = string_used[i] && boost_nxt && !str_off[i];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dim_r      <= 1'b0;
      low_cnt_r  <= '0;
      latch_r    <= 1'b0;
      ext_hold_r <= 1'b0;
      oe_r       <= 1'b0;
      boost_r    <= 1'b0;
      sink_r     <= '0;
    end else begin
      dim_r      <= dim_nxt;
      low_cnt_r  <= low_cnt_nxt;
      latch_r    <= latch_nxt;
      ext_hold_r <= ext_hold_nxt;
      oe_r       <= oe_nxt;
      boost_r    <= boost_nxt;
      sink_r     <= sink_nxt;
    end
  end

  assign fault_line_out = 1'b0;
  assign fault_line_oe  = oe_r;
  assign boost_en       = boost_r;
  // Disconnect switch stays on even under external shutdown
  assign disconnect_on  = 1'b1;
  assign sink_en        = sink_r;

  property p_ext_stop;
    @(posedge clk) disable iff (!resetn)
      ext_low |=> !boost_en && (sink_en == '0);
  endproperty
  a_ext_stop: assert property (p_ext_stop) else $error("external low did not stop");

  property p_iso_ignore;
    @(posedge clk) disable iff (!resetn)
      !mode_all_out && !latch_nxt |=> boost_en;
  endproperty
  a_iso_ignore: assert property (p_iso_ignore) else $error("isolate mode reacted");

  property p_latch_keep;
    @(posedge clk) disable iff (!resetn)
      latch_r && dim_in |=> latch_r && fault_line_oe;
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch lost");

  property p_restart;
    @(posedge clk) disable iff (!resetn)
      $rose(boost_en) && mode_all_out |-> !$past(ext_low) && !$past(latch_nxt);
  endproperty
  a_restart: assert property (p_restart) else $error("restart while held low");

  property p_dim_low_quiet;
    @(posedge clk) disable iff (!resetn)
      !dim_in && !dim_r && (str_flag == '0) |=> (str_flag == '0);
  endproperty
  a_dim_low_quiet: assert property (p_dim_low_quiet) else $error("action while dim low");

  property p_off_flag;
    @(posedge clk) disable iff (!resetn)
      |str_off |=> fault_line_oe;
  endproperty
  a_off_flag: assert property (p_off_flag) else $error("fault not driven");

  property p_others_run;
    @(posedge clk) disable iff (!resetn)
      !mode_all_out && boost_nxt |=> (sink_en == $past(string_used & ~str_off));
  endproperty
  a_others_run: assert property (p_others_run) else $error("healthy string off");

  property p_clear_long_low;
    @(posedge clk) disable iff (!resetn)
      latch_r && !dim_in && (low_cnt_r == RW'(RST_CYCLES)) && !latch_fault_evt |=> !latch_r;
  endproperty
  a_clear_long_low: assert property (p_clear_long_low) else $error("latch not cleared");

  property p_clear_time;
    @(posedge clk) disable iff (!resetn)
      $fell(latch_r) |-> $past(low_cnt_r) == RW'(RST_CYCLES);
  endproperty
  a_clear_time: assert property (p_clear_time) else $error("latch cleared early");
endmodule
`default_nettype wire

//--- lsf_top_tb.sv
// Bench for the fault supervisor: table of fault-wire cases, then hand tests.
// Assumes lsf_peer resolves the shared wire; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module lsf_top_tb;
  import lsf_pkg::*;
  localparam int DET = 20;
  // Short latch-clear count keeps the run brief
  localparam int RST = 50;
  typedef struct {logic mode; logic ext; logic boost; logic [5:0] sink;} lsf_row_t;
  lsf_row_t   rows [4];
  logic       clk = 0, resetn = 0, mode = 0, dim = 1, lfe = 0, pull = 0;
  logic       line, oe, fout, boost, disc;
  logic [5:0] thr = 6'h0, reg_ok = 6'h3, low = 6'h0, used = 6'h3, sink;
  int         error_cnt = 0, total_checks = 0;
  always #50 clk = ~clk;
  lsf_top #(.N_STR(6), .DET_CYCLES(DET), .RST_CYCLES(RST)) i_dut (
    .clk(clk), .resetn(resetn), .mode_all_out(mode), .dim_in(dim),
    .above_partial_short_threshold(thr), .in_regulation(reg_ok),
    .below_low_level(low), .string_used(used), .latch_fault_evt(lfe),
    .fault_line_in(line), .fault_line_out(fout), .fault_line_oe(oe),
    .boost_en(boost), .disconnect_on(disc), .sink_en(sink));
  lsf_peer i_peer (.dev_oe(oe), .pull_low(pull), .line(line));
  task automatic chk_vec(string n, logic [5:0] e, logic [5:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    chk_vec(n, {5'h0, e}, {5'h0, g});
  endtask
  task automatic chk_pwr(logic b, logic [5:0] s);
    chk_bit("boost_en", b, boost);
    chk_bit("disconnect_on", 1'b1, disc);
    chk_vec("sink_en", s, sink);
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset;
    resetn = 0;
    cyc(20);
    chk_pwr(1'b0, 6'h0);
    chk_bit("oe", 1'b0, oe);
    chk_bit("fault_line_out", 1'b0, fout);
    resetn = 1;
    cyc(3);
    chk_pwr(1'b1, 6'h3);
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(20_000 * 100);
    error_cnt++;
    end_of_test();
  end
  initial begin
    rows[0] = '{1'b0, 1'b1, 1'b1, 6'h3};
    rows[1] = '{1'b1, 1'b0, 1'b1, 6'h3};
    rows[2] = '{1'b1, 1'b1, 1'b0, 6'h0};
    rows[3] = '{1'b1, 1'b0, 1'b1, 6'h3};
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].mode !== mode) begin
        mode = rows[i].mode;
        pull = 0;
        do_reset();
      end
      pull = rows[i].ext;
      cyc(3);
      chk_pwr(rows[i].boost, rows[i].sink);
      chk_bit("oe", 1'b0, oe);
    end
    pull = 0;
    mode = 0;
    do_reset();
    // Candidate on string one while dimming is low
    dim = 0;
    thr = 6'h2;
    low = 6'h1;
    cyc(3 * DET);
    chk_bit("oe", 1'b0, oe);
    dim = 1;
    cyc(DET - 3);
    chk_vec("sink_en", 6'h3, sink);
    cyc(10);
    chk_pwr(1'b1, 6'h1);
    chk_bit("line", 1'b0, line);
    dim = 0;
    cyc(5);
    dim = 1;
    cyc(DET - 3);
    chk_vec("sink_en", 6'h3, sink);
    chk_bit("oe", 1'b1, oe);
    cyc(10);
    chk_vec("sink_en", 6'h1, sink);
    dim = 0;
    thr = 6'h0;
    cyc(5);
    dim = 1;
    cyc(DET + 10);
    chk_vec("sink_en", 6'h3, sink);
    chk_bit("oe", 1'b1, oe);
    dim = 0;
    cyc(5);
    dim = 1;
    cyc(5);
    chk_bit("oe", 1'b0, oe);
    // Latched fault in shutdown-all mode, wire left high by the peer
    mode = 1;
    do_reset();
    lfe = 1;
    cyc(1);
    lfe = 0;
    cyc(40);
    chk_bit("fault_line_oe", 1'b1, oe);
    chk_bit("line", 1'b0, line);
    chk_pwr(1'b0, 6'h0);
    dim = 0;
    cyc(RST - 5);
    chk_bit("boost_en", 1'b0, boost);
    cyc(10);
    dim = 1;
    cyc(3);
    chk_pwr(1'b1, 6'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
